// >>> src/psram_bus_if.sv
// RAM die bus decoder: link-clock command decode, core-clock array access
`timescale 1ns/1ps
`include "psram_defs.svh"
// Summary of operation
// - Wait is a data-valid flag only in synchronous mode; async drives idle.
// - Shared wait line is driven only while this die is selected.
// - Array writes change only byte lanes whose enables are low.
// - A write started by the write strobe ignores the output strobe.
// - No-operation reports standby or active from work in progress.
// - Synchronous operations are sampled on the rising bus clock edge.
// - Burst read data drivers follow the output strobe, not the clock.
// - Data bus floats when deselected or output disabled.
module psram_bus_if (
  input  wire logic                sys_clk_in,
  input  wire logic                srst_in,
  input  wire logic                ce_in,
  input  wire logic                bus_clk_in,
  input  wire logic                cs_n_in,
  input  wire logic                address_valid_n_in,
  input  wire logic                write_n_in,
  input  wire logic                output_n_in,
  input  wire logic                upper_byte_lane_n_in,
  input  wire logic                lower_byte_lane_n_in,
  input  wire logic                config_register_select_in,
  input  wire logic [`ADDR_W-1:0]  addr_in,
  input  wire logic [`DATA_W-1:0]  dq_in,
  output logic      [`DATA_W-1:0]  dq_out,
  output logic                     dq_oe_out,
  output logic                     wait_out,
  output logic                     wait_oe_out,
  output logic      [1:0]          power_state_out
);
  localparam int DEPTH = `BUF_DEPTH;

  // Crossing registers from the core side, declared early for the link logic
  logic                  ack_tgl_reg, ack_tgl_next;
  logic [`DATA_W-1:0]    rsp_data_reg, rsp_data_next;

  // Synchronisers into the link domain; the first stage feeds only the second
  logic rst_l1_reg, rst_l2_reg, ce_l1_reg, ce_l2_reg, ack_l1_reg, ack_l2_reg;
  always_ff @(posedge bus_clk_in) begin
    rst_l1_reg <= srst_in;
    rst_l2_reg <= rst_l1_reg;
    ce_l1_reg  <= ce_in;
    ce_l2_reg  <= ce_l1_reg;
    ack_l1_reg <= ack_tgl_reg;
    ack_l2_reg <= ack_l1_reg;
  end

  // Link-domain state
  psram_pkg::link_state_t  state_reg, state_next;
  psram_pkg::power_t       pwr_reg, pwr_next;
  psram_pkg::req_t         req_word_reg, req_word_next;
  logic                    req_tgl_reg, req_tgl_next;
  logic [`ADDR_W-1:0]      addr_reg, addr_next;
  logic [`DATA_W-1:0]      dq_reg, dq_next;
  logic [`DATA_W-1:0]      refresh_config_reg, refresh_config_next;
  logic [`DATA_W-1:0]      bus_config_reg, bus_config_next;
  logic                    wait_reg, wait_next;
  logic                    pending, async_mode, init_cyc;
  logic [1:0]              register_select_address_bits;
  logic [1:0]              lanes_n;

  assign pending    = req_tgl_reg ^ ack_l2_reg;
  assign async_mode = bus_config_reg[`BUS_ASYNC_BIT];
  assign init_cyc   = !cs_n_in && !address_valid_n_in;
  assign register_select_address_bits = addr_in[19:18];
  assign lanes_n    = {upper_byte_lane_n_in, lower_byte_lane_n_in};

  // Command decode, sampled on the rising bus clock edge
  always_comb begin
    state_next          = state_reg;
    addr_next           = addr_reg;
    req_tgl_next        = req_tgl_reg;
    req_word_next       = req_word_reg;
    dq_next             = dq_reg;
    refresh_config_next = refresh_config_reg;
    bus_config_next     = bus_config_reg;
    if (cs_n_in) begin
      state_next = psram_pkg::LINK_IDLE; // Deselect ends any burst
    end else if (init_cyc && !pending) begin
      if (config_register_select_in) begin
        if (!write_n_in) begin
          unique case (register_select_address_bits)
            `SEL_REFRESH: refresh_config_next = addr_in[`DATA_W-1:0];
            `SEL_BUS:     bus_config_next     = addr_in[`DATA_W-1:0];
            default:      ; // Ident is read only
          endcase
          state_next = psram_pkg::LINK_IDLE;
        end else begin
          unique case (register_select_address_bits)
            `SEL_REFRESH: dq_next = refresh_config_reg;
            `SEL_BUS:     dq_next = bus_config_reg;
            `SEL_IDENT:   dq_next = `IDENT_VAL;
            default:      dq_next = 16'h0000;
          endcase
          state_next = psram_pkg::LINK_HOLD;
        end
      end else begin
        addr_next = addr_in;
        if (!write_n_in) begin
          if (async_mode) begin
            req_word_next = '{wr: 1'b1, lanes_n: lanes_n, addr: addr_in, data: dq_in};
            req_tgl_next  = !req_tgl_reg;
            state_next    = psram_pkg::LINK_WAIT;
          end else begin
            state_next = psram_pkg::LINK_ARMW;
          end
        end else begin
          req_word_next = '{wr: 1'b0, lanes_n: 2'h3, addr: addr_in, data: 16'h0000};
          req_tgl_next  = !req_tgl_reg;
          state_next    = psram_pkg::LINK_WAIT;
        end
      end
    end else begin
      unique case (state_reg)
        psram_pkg::LINK_WAIT: begin
          if (!pending) begin
            if (req_word_reg.wr) begin
              addr_next  = addr_reg + 20'h00001;
              state_next = async_mode ? psram_pkg::LINK_IDLE : psram_pkg::LINK_ARMW;
            end else begin
              dq_next    = rsp_data_reg;
              state_next = async_mode ? psram_pkg::LINK_HOLD : psram_pkg::LINK_DATA;
            end
          end
        end
        psram_pkg::LINK_DATA: begin
          // Host took the word this edge; fetch the next one of the burst
          addr_next     = addr_reg + 20'h00001;
          req_word_next = '{wr: 1'b0, lanes_n: 2'h3, addr: addr_reg + 20'h00001,
                            data: 16'h0000};
          req_tgl_next  = !req_tgl_reg;
          state_next    = psram_pkg::LINK_WAIT;
        end
        psram_pkg::LINK_ARMW: begin
          req_word_next = '{wr: 1'b1, lanes_n: lanes_n, addr: addr_reg, data: dq_in};
          req_tgl_next  = !req_tgl_reg;
          state_next    = psram_pkg::LINK_WAIT;
        end
        default: ; // Idle and hold keep their state
      endcase
    end
    wait_next = !async_mode && !cs_n_in && (state_next == psram_pkg::LINK_WAIT);
    // Power report follows work in progress, also in no-operation cycles
    if (cs_n_in) begin
      pwr_next = refresh_config_reg[`DPD_OFF_BIT] ? psram_pkg::PWR_STANDBY
                                                  : psram_pkg::PWR_DEEP;
    end else if (state_next != psram_pkg::LINK_IDLE || pending) begin
      pwr_next = psram_pkg::PWR_ACTIVE;
    end else begin
      pwr_next = psram_pkg::PWR_STANDBY;
    end
  end

  // Link registers, frozen while the clock enable is low
  always_ff @(posedge bus_clk_in) begin
    if (rst_l2_reg) begin
      state_reg          <= psram_pkg::LINK_IDLE;
      pwr_reg            <= psram_pkg::PWR_STANDBY;
      req_word_reg       <= '0;
      req_tgl_reg        <= 1'b0;
      addr_reg           <= '0;
      dq_reg             <= '0;
      refresh_config_reg <= `REFRESH_RST;
      bus_config_reg     <= `BUS_RST;
      wait_reg           <= 1'b0;
    end else if (ce_l2_reg) begin
      state_reg          <= state_next;
      pwr_reg            <= pwr_next;
      req_word_reg       <= req_word_next;
      req_tgl_reg        <= req_tgl_next;
      addr_reg           <= addr_next;
      dq_reg             <= dq_next;
      refresh_config_reg <= refresh_config_next;
      bus_config_reg     <= bus_config_next;
      wait_reg           <= wait_next;
    end
  end

  // Drivers follow the strobes directly, so a clock would be too late to float them
  assign dq_out          = dq_reg;
  assign dq_oe_out       = (state_reg == psram_pkg::LINK_DATA || state_reg == psram_pkg::LINK_HOLD)
                           && !cs_n_in && !output_n_in;
  assign wait_out        = wait_reg;
  assign wait_oe_out     = !cs_n_in;
  assign power_state_out = pwr_reg;

  // Core-domain side: request synchroniser, array access, answer buffer
  logic                  req_s1_reg, req_s2_reg;
  logic                  req_seen_reg, req_seen_next, busy_reg, busy_next;
  logic [1:0]            count_reg, count_next;
  logic                  wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [`DATA_W-1:0]    ent_reg [DEPTH];
  logic [`DATA_W-1:0]    ent_next [DEPTH];
  logic                  new_req, accept, push, pop, in_ready, out_valid, out_ready;
  mem_port_if            mport ();

  always_ff @(posedge sys_clk_in) begin
    req_s1_reg <= req_tgl_reg;
    req_s2_reg <= req_s1_reg;
  end

  // The buffer's ready stalls acceptance, so a slow answer path loses no word
  assign in_ready  = (count_reg != 2'(DEPTH));
  assign new_req   = req_s2_reg ^ req_seen_reg;
  assign accept    = new_req && !busy_reg && in_ready;
  assign push      = mport.rvalid;
  assign out_valid = (count_reg != 2'h0);
  assign out_ready = ack_tgl_reg ^ req_seen_reg; // An answer is owed
  assign pop       = out_valid && out_ready;

  assign mport.en      = accept && ce_in;
  assign mport.wr      = req_word_reg.wr;
  assign mport.lanes_n = req_word_reg.lanes_n;
  assign mport.addr    = req_word_reg.addr;
  assign mport.wdata   = req_word_reg.data;

  // Buffer entries
  for (genvar e = 0; e < DEPTH; e++) begin : g_ent
    always_comb begin
      ent_next[e] = (push && wr_ptr_reg == 1'(e)) ? mport.rdata : ent_reg[e];
    end
    always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
        ent_reg[e] <= '0;
      end else if (ce_in) begin
        ent_reg[e] <= ent_next[e];
      end
    end
  end

  // Access sequencing and answer toggle
  always_comb begin
    req_seen_next = accept ? !req_seen_reg : req_seen_reg;
    busy_next     = accept ? 1'b1 : (push ? 1'b0 : busy_reg);
    wr_ptr_next   = push ? !wr_ptr_reg : wr_ptr_reg;
    rd_ptr_next   = pop ? !rd_ptr_reg : rd_ptr_reg;
    count_next    = count_reg + 2'(push) - 2'(pop);
    ack_tgl_next  = pop ? !ack_tgl_reg : ack_tgl_reg;
    rsp_data_next = pop ? ent_reg[rd_ptr_reg] : rsp_data_reg; // Held until next answer
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      req_seen_reg <= 1'b0;
      busy_reg     <= 1'b0;
      wr_ptr_reg   <= 1'b0;
      rd_ptr_reg   <= 1'b0;
      count_reg    <= 2'h0;
      ack_tgl_reg  <= 1'b0;
      rsp_data_reg <= '0;
    end else if (ce_in) begin
      req_seen_reg <= req_seen_next;
      busy_reg     <= busy_next;
      wr_ptr_reg   <= wr_ptr_next;
      rd_ptr_reg   <= rd_ptr_next;
      count_reg    <= count_next;
      ack_tgl_reg  <= ack_tgl_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  psram_array u_array (
    .clk_in (sys_clk_in),
    .rst_in (srst_in),
    .ce_in  (ce_in),
    .port   (mport.mem)
  );

  // Link-domain checks; the last one, on the buffer stall, runs on the core clock
  property p_wait_async;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (async_mode && $stable(bus_config_reg)) |=> !wait_out;
  endproperty
  a_wait_async: assert property (p_wait_async) else $error("wait asserted in async mode");
  property p_wait_float;
    @(posedge bus_clk_in) disable iff (rst_l2_reg) cs_n_in |-> !wait_oe_out && !dq_oe_out;
  endproperty
  a_wait_float: assert property (p_wait_float) else $error("drives while deselected");
  property p_dq_float;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (output_n_in || state_reg == psram_pkg::LINK_WAIT) |-> !dq_oe_out;
  endproperty
  a_dq_float: assert property (p_dq_float) else $error("data bus not floated");
  property p_oe_direct;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (state_reg == psram_pkg::LINK_HOLD && !cs_n_in && !output_n_in) |-> dq_oe_out;
  endproperty
  a_oe_direct: assert property (p_oe_direct) else $error("driver not following strobe");
  property p_write_ignores_oe;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (ce_l2_reg && state_reg == psram_pkg::LINK_IDLE && !pending && init_cyc && !write_n_in
       && !config_register_select_in && async_mode)
      |=> state_reg == psram_pkg::LINK_WAIT && req_word_reg.wr;
  endproperty
  a_write_ignores_oe: assert property (p_write_ignores_oe) else $error("write not started");
  property p_power_nop;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (ce_l2_reg && !cs_n_in && address_valid_n_in && state_reg == psram_pkg::LINK_IDLE
       && !pending) |=> power_state_out == psram_pkg::PWR_STANDBY;
  endproperty
  a_power_nop: assert property (p_power_nop) else $error("idle nop not standby");
  property p_data_on_edge;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (ce_l2_reg && !cs_n_in && address_valid_n_in && state_reg == psram_pkg::LINK_WAIT
       && !pending && !req_word_reg.wr) |=> dq_out == $past(rsp_data_reg);
  endproperty
  a_data_on_edge: assert property (p_data_on_edge) else $error("read word not loaded");
  property p_fetch_bus;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (ce_l2_reg && init_cyc && !pending && config_register_select_in && write_n_in
       && addr_in[19:18] == `SEL_BUS) |=> state_reg == psram_pkg::LINK_HOLD
       && dq_out == bus_config_reg;
  endproperty
  a_fetch_bus: assert property (p_fetch_bus) else $error("fetch returned wrong register");
  property p_burst_addr;
    @(posedge bus_clk_in) disable iff (rst_l2_reg)
      (ce_l2_reg && init_cyc && !pending && write_n_in && !config_register_select_in)
      |=> req_word_reg.addr == $past(addr_in) && pending;
  endproperty
  a_burst_addr: assert property (p_burst_addr) else $error("init address not captured");
  property p_stall;
    @(posedge sys_clk_in) disable iff (srst_in) (count_reg == 2'(DEPTH)) |-> !mport.en;
  endproperty
  a_stall: assert property (p_stall) else $error("access taken with buffer full");

  c_burst_read: cover property (@(posedge bus_clk_in) disable iff (rst_l2_reg)
    state_reg == psram_pkg::LINK_DATA ##[1:100] state_reg == psram_pkg::LINK_DATA);
  c_burst_write: cover property (@(posedge bus_clk_in) disable iff (rst_l2_reg)
    state_reg == psram_pkg::LINK_ARMW ##1 state_reg == psram_pkg::LINK_WAIT);
  c_fetch: cover property (@(posedge bus_clk_in) disable iff (rst_l2_reg)
    state_reg == psram_pkg::LINK_HOLD && dq_oe_out);
  c_deep: cover property (@(posedge bus_clk_in) disable iff (rst_l2_reg)
    power_state_out == psram_pkg::PWR_DEEP);
endmodule

// >>> src/psram_defs.svh
// Offsets, field positions, reset values and sizes of the RAM bus block
`ifndef PSRAM_DEFS_SVH
`define PSRAM_DEFS_SVH

`define ADDR_W        20
`define DATA_W        16
`define LANES         2
`define LANE_W        8
`define BUF_DEPTH     2
// Register select codes on the two top address bits
`define SEL_REFRESH   2'h0
`define SEL_BUS       2'h2
`define SEL_IDENT     2'h1
// Register fields and reset values
`define BUS_ASYNC_BIT 15
`define DPD_OFF_BIT   4
`define REFRESH_RST   16'h0010
`define BUS_RST       16'h8000
// Identification word; the value is arbitrary
`define IDENT_VAL     16'h0a5c

`endif

// >>> src/psram_pkg.sv
// Types shared by the RAM bus block
package psram_pkg;
  // Link state machine, Gray coded along idle, wait, data, hold, write-arm
  typedef enum logic [2:0] {
    LINK_IDLE = 3'h0,
    LINK_WAIT = 3'h1,
    LINK_DATA = 3'h3,
    LINK_HOLD = 3'h2,
    LINK_ARMW = 3'h6
  } link_state_t;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'h0,
    PWR_ACTIVE  = 2'h1,
    PWR_DEEP    = 2'h2
  } power_t;

  // One array access passed from the link domain to the core domain
  typedef struct packed {
    logic        wr;
    logic [1:0]  lanes_n;
    logic [19:0] addr;
    logic [15:0] data;
  } req_t;
endpackage

// >>> src/mem_port_if.sv
// Interface between the access sequencer and the word array
`timescale 1ns/1ps
`include "psram_defs.svh"
interface mem_port_if;
  logic                en;
  logic                wr;
  logic [`LANES-1:0]   lanes_n;
  logic [`ADDR_W-1:0]  addr;
  logic [`DATA_W-1:0]  wdata;
  logic [`DATA_W-1:0]  rdata;
  logic                rvalid;

  modport ctrl (output en, output wr, output lanes_n, output addr, output wdata,
                input rdata, input rvalid);
  modport mem  (input en, input wr, input lanes_n, input addr, input wdata,
                output rdata, output rvalid);
endinterface

// >>> src/psram_array.sv
// Word array with per-lane write enables and registered read data
`timescale 1ns/1ps
`include "psram_defs.svh"
module psram_array (
  input  wire logic     clk_in,
  input  wire logic     rst_in,
  input  wire logic     ce_in,
  mem_port_if.mem       port
);
  logic [`DATA_W-1:0]  mem_arr [0:(1<<`ADDR_W)-1];
  logic [`DATA_W-1:0]  rdata_reg;
  logic                rvalid_reg;

  // Only lanes with a low enable are written; read returns the word before the write
  always_ff @(posedge clk_in) begin
    if (ce_in && port.en && port.wr) begin
      for (int l = 0; l < `LANES; l++) begin
        if (!port.lanes_n[l]) begin
          mem_arr[port.addr][l*`LANE_W +: `LANE_W] <= port.wdata[l*`LANE_W +: `LANE_W];
        end
      end
    end
    if (ce_in && port.en) begin
      rdata_reg <= mem_arr[port.addr];
    end
  end

  // Valid strobe follows each access by one cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rvalid_reg <= 1'b0;
    end else if (ce_in) begin
      rvalid_reg <= port.en;
    end
  end

  assign port.rdata  = rdata_reg;
  assign port.rvalid = rvalid_reg;

  // Helper capture of the last write, read only by the check below
  logic                chk_valid_reg;
  logic [`ADDR_W-1:0]  chk_addr_reg;
  logic [`LANES-1:0]   chk_lanes_reg;
  logic [`DATA_W-1:0]  chk_old_reg;
  logic [`DATA_W-1:0]  chk_data_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chk_valid_reg <= 1'b0;
    end else if (ce_in && port.en && port.wr) begin
      chk_valid_reg <= 1'b1;
      chk_addr_reg  <= port.addr;
      chk_lanes_reg <= port.lanes_n;
      chk_old_reg   <= mem_arr[port.addr];
      chk_data_reg  <= port.wdata;
    end
  end

  property p_lane_mask;
    @(posedge clk_in) disable iff (rst_in)
      chk_valid_reg |-> mem_arr[chk_addr_reg] ==
        {chk_lanes_reg[1] ? chk_old_reg[15:8] : chk_data_reg[15:8],
         chk_lanes_reg[0] ? chk_old_reg[7:0]  : chk_data_reg[7:0]};
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("byte lane mask broken");
endmodule

// >>> test/psram_host.sv
// Host memory controller model that drives the shared RAM bus
`timescale 1ns/1ps
`include "psram_defs.svh"
module psram_host (
  input  wire logic               bus_clk_in,
  input  wire logic [`DATA_W-1:0] dev_dq_in,
  input  wire logic               dev_oe_in,
  output logic                    cs_n_out,
  output logic                    address_valid_n_out,
  output logic                    write_n_out,
  output logic                    output_n_out,
  output logic                    upper_byte_lane_n_out,
  output logic                    lower_byte_lane_n_out,
  output logic                    config_register_select_out,
  output logic      [`ADDR_W-1:0] addr_out,
  output logic      [`DATA_W-1:0] dq_out
);
  logic [`DATA_W-1:0] drv;
  logic               drv_en;

  // Released bus shows the inverse of the last word so stale data cannot pass
  assign dq_out = drv_en ? drv : (dev_oe_in ? dev_dq_in : ~drv);

  // Idle bus at time zero
  initial begin
    {cs_n_out, address_valid_n_out, write_n_out, output_n_out} = 4'hf;
    {upper_byte_lane_n_out, lower_byte_lane_n_out} = 2'h3;
    config_register_select_out = 1'b0;
    addr_out = '0;
    drv = '0;
    drv_en = 1'b0;
  end

  // Init cycle then data phase; all changes land just after a rising edge
  task automatic start(input logic reg_sel, input logic we, input logic oe, input logic [1:0] ln,
                       input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge bus_clk_in);
    cs_n_out <= 1'b0;
    address_valid_n_out <= 1'b0;
    write_n_out <= we;
    output_n_out <= oe | ~we;
    {upper_byte_lane_n_out, lower_byte_lane_n_out} <= ln;
    config_register_select_out <= reg_sel;
    addr_out <= a;
    drv <= d;
    drv_en <= ~we;
    @(posedge bus_clk_in);
    address_valid_n_out <= 1'b1;
    if (reg_sel && we) begin
      output_n_out <= 1'b0;
    end
  endtask

  // Deselect; the register select goes low for standby
  task automatic stop();
    @(posedge bus_clk_in);
    {cs_n_out, address_valid_n_out, write_n_out, output_n_out} <= 4'hf;
    config_register_select_out <= 1'b0;
    drv_en <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge bus_clk_in);
  endtask
endmodule

// >>> test/psram_bus_operation_interface_bench.sv
// Self-checking bench for the RAM bus decoder
`timescale 1ns/1ps
`include "psram_defs.svh"
module psram_bus_operation_interface_bench;
  logic               sys_clk_in, bus_clk, srst_in, ce;
  logic               cs_n, address_valid_n, we_n, oe_n, config_register_select;
  logic               upper_byte_lane_n, lower_byte_lane_n;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] dq_bus, dq_out;
  logic               dq_oe_out, wait_out, wait_oe_out;
  logic [1:0]         power_state_out;
  logic [`DATA_W-1:0] mem [4];
  logic [`DATA_W-1:0] d;
  logic [1:0]         ln;
  integer             seed;
  int                 err_total, total_checks, i, k;

  // Core and link clocks, unrelated in phase
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    bus_clk = 1'b0;
    #1.3;
    forever #3 bus_clk = ~bus_clk;
  end

  psram_bus_if psram_bus_if_inst (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce), .bus_clk_in(bus_clk),
    .cs_n_in(cs_n), .address_valid_n_in(address_valid_n), .write_n_in(we_n),
    .output_n_in(oe_n), .upper_byte_lane_n_in(upper_byte_lane_n),
    .lower_byte_lane_n_in(lower_byte_lane_n),
    .config_register_select_in(config_register_select), .addr_in(addr), .dq_in(dq_bus),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .wait_out(wait_out), .wait_oe_out(wait_oe_out),
    .power_state_out(power_state_out));

  psram_host psram_host_inst (
    .bus_clk_in(bus_clk), .dev_dq_in(dq_out), .dev_oe_in(dq_oe_out), .cs_n_out(cs_n),
    .address_valid_n_out(address_valid_n), .write_n_out(we_n), .output_n_out(oe_n),
    .upper_byte_lane_n_out(upper_byte_lane_n), .lower_byte_lane_n_out(lower_byte_lane_n),
    .config_register_select_out(config_register_select), .addr_out(addr), .dq_out(dq_bus));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Let the edge's register updates land before sampling
  task automatic settle(input int n);
    psram_host_inst.idle(n);
    #1;
  endtask

  // Lane merge worked out from the enables alone
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] w,
                                        input logic [1:0] l);
    return {l[1] ? o[15:8] : w[15:8], l[0] ? o[7:0] : w[7:0]};
  endfunction

  task automatic fetch(input logic [1:0] sel, input logic [15:0] e);
    psram_host_inst.start(1'b1, 1'b1, 1'b0, 2'h0, {sel, 18'h0}, 16'h0);
    settle(3);
    chk("fetch", e, dq_out);
    chk("wait_oe", 16'h1, {15'h0, wait_oe_out});
    psram_host_inst.stop();
    settle(2);
    chk("dq_oe idle", 16'h0, {15'h0, dq_oe_out});
    chk("wait_oe idle", 16'h0, {15'h0, wait_oe_out});
  endtask

  task automatic setreg(input logic [1:0] sel, input logic [15:0] v);
    psram_host_inst.start(1'b1, 1'b0, 1'b1, 2'h3, {sel, 2'h0, v}, 16'h0);
    psram_host_inst.stop();
    settle(4);
  endtask

  // Writes give no completion sign in async mode, so the longest crossing is waited out
  task automatic wr(input int a, input logic [15:0] w, input logic [1:0] l);
    psram_host_inst.start(1'b0, 1'b0, 1'b1, l, a[19:0], w);
    psram_host_inst.stop();
    mem[a] = merge(mem[a], w, l);
    settle(80);
  endtask

  task automatic rd_async(input int a);
    psram_host_inst.start(1'b0, 1'b1, 1'b0, 2'h3, a[19:0], 16'h0);
    // Wait for the driver to open; a stale word equal to the answer must not end the wait
    for (k = 0; k < 100 && dq_oe_out !== 1'b1; k++) settle(1);
    chk("async read", mem[a], dq_out);
    chk("async wait", 16'h0, {15'h0, wait_out});
    chk("dq_oe read", 16'h1, {15'h0, dq_oe_out});
    psram_host_inst.stop();
    settle(4);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog: the full sequence needs well under 20 us of link time
  initial begin
    #100000;
    err_total++;
    close_out();
  end

  initial begin
    seed = 69659;
    ce = 1'b1;
    err_total = 0;
    total_checks = 0;
    srst_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    settle(8);
    fetch(2'h0, `REFRESH_RST);
    fetch(2'h2, `BUS_RST);
    fetch(2'h1, `IDENT_VAL);
    // A set made while the clock enable is low must leave no trace
    @(posedge sys_clk_in) ce <= 1'b0;
    settle(4);
    setreg(2'h0, 16'h1234);
    @(posedge sys_clk_in) ce <= 1'b1;
    settle(4);
    fetch(2'h0, `REFRESH_RST);
    chk("power idle", 16'h0, {14'h0, power_state_out});
    // Full words first, then partial lanes with corner enables
    for (i = 0; i < 4; i++) wr(i, 16'hffff ^ 16'(i), 2'h0);
    for (i = 0; i < 7; i++) begin
      d = 16'($random(seed));
      ln = (i < 3) ? 2'(i) : 2'($random(seed));
      wr(i % 4, d, ln);
    end
    for (i = 0; i < 4; i++) rd_async(i);
    d = 16'($random(seed)) & 16'h7fef;
    setreg(2'h0, d);
    fetch(2'h0, d);
    chk("deep power", 16'h2, {14'h0, power_state_out});
    setreg(2'h0, `REFRESH_RST);
    setreg(2'h2, 16'h0000);
    fetch(2'h2, 16'h0000);
    // Sync write burst to words 1 and 2; the second capture lands on the edge after wait drops
    d = 16'($random(seed));
    ln = 2'($random(seed)) & 2'h1;
    psram_host_inst.start(1'b0, 1'b0, 1'b1, ln, 20'h1, d);
    for (k = 0; k < 100; k++) begin
      settle(1);
      if (wait_out === 1'b0) break;
    end
    psram_host_inst.stop();
    mem[1] = merge(mem[1], d, ln);
    mem[2] = merge(mem[2], d, ln);
    settle(80);
    // Two-word sync burst read back; each word valid when wait drops
    psram_host_inst.start(1'b0, 1'b1, 1'b0, 2'h3, 20'h1, 16'h0);
    for (i = 0; i < 2; i++) begin
      for (k = 0; k < 100; k++) begin
        settle(1);
        if (wait_out === 1'b0) break;
      end
      chk("burst word", mem[i+1], dq_out);
      chk("burst dq_oe", 16'h1, {15'h0, dq_oe_out});
      chk("burst power", 16'h1, {14'h0, power_state_out});
    end
    psram_host_inst.stop();
    settle(60);
    chk("standby", 16'h0, {14'h0, power_state_out});
    chk("float", 16'h0, {15'h0, dq_oe_out});
    close_out();
  end
endmodule
